// file: hdl/cmsd_defines.vh
// Constants for the control mode and strap decoder
`ifndef CMSD_DEFINES_VH
`define CMSD_DEFINES_VH
// Control mode codes
`define CMSD_MODE_HW       2'h0
`define CMSD_MODE_SERIAL   2'h1
`define CMSD_MODE_PAR_DS   2'h2
`define CMSD_MODE_PAR_RW   2'h3
// Register offsets
`define CMSD_OFF_INT_CFG   6'h20
`define CMSD_OFF_MASK_A    6'h13
`define CMSD_OFF_MASK_B    6'h14
`define CMSD_OFF_STAT_A    6'h18
`define CMSD_OFF_STAT_B    6'h19
`define CMSD_OFF_SW_CFG    6'h21
`define CMSD_OFF_SW_LOOP   6'h22
`define CMSD_OFF_SW_PULSE  6'h24
`define CMSD_OFF_SW_LINE   6'h25
`define CMSD_OFF_SW_AUX    6'h26
// Reset values
`define CMSD_RST_MASK      8'hff
`define CMSD_RST_INT_CFG   8'h00
`define CMSD_RST_CFG       8'h00
// Interrupt config fields
`define CMSD_BIT_GMASK     0
`define CMSD_BIT_POL_HIGH  1
// Serial frame: index of the last frame bit and of the last command bit
`define CMSD_SER_BITS      4'hf
`define CMSD_SER_CMD_LAST  4'h7
`endif

// file: hdl/cmsd_sync.v
// Two flip-flop synchroniser for pins from outside the clock domain
`default_nettype none
module cmsd_sync #(
   parameter integer W       = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   // Clock and reset
   input  wire         clock,
   input  wire         rst,
   // Pin side and synchronised side
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] meta_q;

   // First stage feeds only the second stage
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: hdl/cmsd_top.v
// Control mode selection, strap decoding, host ports and interrupt output
`include "cmsd_defines.vh"
`default_nettype none
module cmsd_top (
   // Clock and reset
   input  wire        clock,
   input  wire        rst,
   // Mode straps
   input  wire [1:0]  mode_select,
   // Host port pins
   input  wire        cs_n,
   input  wire        sclk,
   input  wire        shift_edge_select,
   input  wire        serial_in,
   output reg         serial_out,
   output reg         serial_out_oe,
   input  wire [5:0]  addr,
   input  wire [7:0]  data_in,
   output reg  [7:0]  data_out,
   output reg         data_oe,
   input  wire        strobe_or_read_n,
   input  wire        dir_or_write_n,
   output reg         irq_out,
   // Hardware configuration straps
   input  wire        rx_edge_select,
   input  wire [1:0]  rail_coding_select,
   input  wire [1:0]  ch1_loop_select,
   input  wire [1:0]  ch2_loop_select,
   input  wire [3:0]  tx_pattern_select,
   input  wire [7:0]  pulse_shape_select,
   input  wire        tx_high_z,
   input  wire [1:0]  jitter_atten_place,
   input  wire [1:0]  monitor_enable,
   input  wire [1:0]  termination_select,
   input  wire [1:0]  rx_power_down,
   // Interrupt sources, one-cycle pulses on clock
   input  wire [7:0]  irq_src_a,
   input  wire [7:0]  irq_src_b,
   // Receive side
   input  wire        recovered_clock,
   input  wire [1:0]  rx_rail_in,
   output reg  [1:0]  rx_rail_outputs,
   // Effective configuration
   output reg         hw_mode,
   output reg         single_rail,
   output reg         ami_coding,
   output reg         clock_data_recovery,
   output reg  [1:0]  analog_loop,
   output reg  [1:0]  digital_loop,
   output reg  [1:0]  remote_loop,
   output reg  [1:0]  inband_loop,
   output reg  [1:0]  tx_all_ones,
   output reg  [1:0]  tx_prbs,
   output reg  [1:0]  tx_power_down,
   output reg  [7:0]  pulse_shape_out,
   output reg         tx_high_z_out,
   output reg  [1:0]  jitter_atten_out,
   output reg  [1:0]  monitor_out,
   output reg  [1:0]  termination_out,
   output reg  [1:0]  rx_power_down_out
);
   wire [3:0]  ctl_s;
   wire [15:0] bus_s;
   wire [31:0] strap_s;
   wire [2:0]  link_s;
   reg  [7:0]  mask_a_q, mask_b_q, stat_a_q, stat_b_q, int_cfg_q;
   reg  [7:0]  sw_cfg_q, sw_loop_q, sw_pulse_q, sw_line_q, sw_aux_q;
   reg         sclk_prev_q, rclk_prev_q, wr_prev_q, rd_prev_q;
   reg  [3:0]  bit_cnt_q;
   reg  [7:0]  in_sh_q, out_sh_q, ser_cmd_q, rd_val_q;
   reg  [5:0]  par_addr_q;
   reg  [7:0]  par_data_q;
   reg         dphase_q;
   reg         wr_en, rd_done;
   reg  [5:0]  wr_addr, rd_addr;
   reg  [7:0]  wr_data, rd_val;
   reg  [1:0]  eff_rail, eff_loop1, eff_loop2;
   reg  [3:0]  eff_pat;
   reg         eff_edge;

   // Pins cross into the clock domain before any decoding
   cmsd_sync #(.W(4), .RST_VAL(4'he)) u_ctl_sync (
      .clock(clock), .rst(rst),
      .async_in({cs_n, strobe_or_read_n, dir_or_write_n, sclk}), .sync_out(ctl_s));
   cmsd_sync #(.W(16)) u_bus_sync (
      .clock(clock), .rst(rst),
      .async_in({shift_edge_select, serial_in, addr, data_in}), .sync_out(bus_s));
   cmsd_sync #(.W(32)) u_strap_sync (
      .clock(clock), .rst(rst),
      .async_in({mode_select, rx_edge_select, rail_coding_select, ch1_loop_select, ch2_loop_select,
                 tx_pattern_select, pulse_shape_select, tx_high_z, jitter_atten_place,
                 monitor_enable, termination_select, rx_power_down, 2'h0}),
      .sync_out(strap_s));
   cmsd_sync #(.W(3)) u_link_sync (
      .clock(clock), .rst(rst),
      .async_in({recovered_clock, rx_rail_in}), .sync_out(link_s));

   wire [1:0] mode_s   = strap_s[31:30];
   wire       cs_act   = ~ctl_s[3];
   wire       strb_s   = ctl_s[2];
   wire       dirw_s   = ctl_s[1];
   wire       sclk_s   = ctl_s[0];
   wire       edge_sel = bus_s[15];
   wire       sdi_s    = bus_s[14];
   wire       is_hw    = (mode_s == `CMSD_MODE_HW);
   wire       is_ser   = (mode_s == `CMSD_MODE_SERIAL);
   wire       is_ds    = (mode_s == `CMSD_MODE_PAR_DS);
   wire       is_par   = is_ds | (mode_s == `CMSD_MODE_PAR_RW);
   wire       ser_on   = is_ser & cs_act;
   // two strobe styles on shared pins
   wire       wr_act   = is_par & cs_act & (is_ds ? (~strb_s & ~dirw_s) : ~dirw_s);
   wire       rd_act   = is_par & cs_act & (is_ds ? (~strb_s & dirw_s) : ~strb_s);
   wire       sclk_r   = sclk_s & ~sclk_prev_q;
   wire       sclk_f   = ~sclk_s & sclk_prev_q;
   // edge select picks the output edge
   wire       act_edge = edge_sel ? sclk_f : sclk_r;
   wire [7:0] byte_now = {sdi_s, in_sh_q[7:1]};

   // Register read multiplexer shared by both ports
   function [7:0] reg_rd;
      input [5:0] a;
      begin
         if (a == `CMSD_OFF_MASK_A)
            reg_rd = mask_a_q;
         else if (a == `CMSD_OFF_MASK_B)
            reg_rd = mask_b_q;
         else if (a == `CMSD_OFF_STAT_A)
            reg_rd = stat_a_q;
         else if (a == `CMSD_OFF_STAT_B)
            reg_rd = stat_b_q;
         else if (a == `CMSD_OFF_INT_CFG)
            reg_rd = int_cfg_q;
         else if (a == `CMSD_OFF_SW_CFG)
            reg_rd = sw_cfg_q;
         else if (a == `CMSD_OFF_SW_LOOP)
            reg_rd = sw_loop_q;
         else if (a == `CMSD_OFF_SW_PULSE)
            reg_rd = sw_pulse_q;
         else if (a == `CMSD_OFF_SW_LINE)
            reg_rd = sw_line_q;
         else if (a == `CMSD_OFF_SW_AUX)
            reg_rd = sw_aux_q;
         else
            reg_rd = 8'h00;
      end
   endfunction

   // Serial port: 8-bit command, LSB first, then 8 data bits
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sclk_prev_q   <= 1'b0;
         bit_cnt_q     <= 4'h0;
         in_sh_q       <= 8'h00;
         out_sh_q      <= 8'h00;
         ser_cmd_q     <= 8'h00;
         dphase_q      <= 1'b0;
         serial_out    <= 1'b0;
         serial_out_oe <= 1'b0;
      end
      else
      begin
         sclk_prev_q   <= sclk_s;
         serial_out_oe <= ser_on & dphase_q;
         if (!ser_on)
         begin
            bit_cnt_q <= 4'h0;
            dphase_q  <= 1'b0;
         end
         else
         begin
            if (sclk_r)
            begin
               in_sh_q   <= byte_now;
               bit_cnt_q <= bit_cnt_q + 4'h1;
               if (bit_cnt_q == `CMSD_SER_CMD_LAST)
               begin
                  ser_cmd_q <= byte_now;
                  if (byte_now[0])
                  begin
                     out_sh_q <= reg_rd(byte_now[6:1]);
                     dphase_q <= 1'b1;
                  end
               end
            end
            // output shifts on the chosen edge
            if (act_edge && dphase_q)
            begin
               serial_out <= out_sh_q[0];
               out_sh_q   <= {1'b0, out_sh_q[7:1]};
            end
         end
      end
   end

   // Parallel port: capture while active, act when the strobe ends
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wr_prev_q  <= 1'b0;
         rd_prev_q  <= 1'b0;
         par_addr_q <= 6'h00;
         par_data_q <= 8'h00;
         data_out   <= 8'h00;
         data_oe    <= 1'b0;
         rd_val_q   <= 8'h00;
      end
      else
      begin
         wr_prev_q <= wr_act;
         rd_prev_q <= rd_act;
         data_oe   <= rd_act;
         if (wr_act || rd_act)
            par_addr_q <= bus_s[13:8];
         if (wr_act)
            par_data_q <= bus_s[7:0];
         if (rd_act)
         begin
            data_out <= reg_rd(bus_s[13:8]);
            rd_val_q <= reg_rd(bus_s[13:8]);
         end
      end
   end

   // Write and read-completion strobes from whichever port is live
   always @*
   begin
      wr_en   = 1'b0;
      wr_addr = par_addr_q;
      wr_data = par_data_q;
      rd_done = 1'b0;
      rd_addr = par_addr_q;
      rd_val  = rd_val_q;
      if (wr_prev_q && !wr_act)
         wr_en = 1'b1;
      if (rd_prev_q && !rd_act)
         rd_done = 1'b1;
      if (ser_on && sclk_r && bit_cnt_q == `CMSD_SER_BITS)
      begin
         wr_en   = ~ser_cmd_q[0];
         wr_addr = ser_cmd_q[6:1];
         wr_data = byte_now;
         rd_done = ser_cmd_q[0];
         rd_addr = ser_cmd_q[6:1];
         rd_val  = reg_rd(ser_cmd_q[6:1]);
      end
   end

   // Register file; status bits clear on read, a new event wins
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         mask_a_q   <= `CMSD_RST_MASK;
         mask_b_q   <= `CMSD_RST_MASK;
         stat_a_q   <= 8'h00;
         stat_b_q   <= 8'h00;
         int_cfg_q  <= `CMSD_RST_INT_CFG;
         sw_cfg_q   <= `CMSD_RST_CFG;
         sw_loop_q  <= `CMSD_RST_CFG;
         sw_pulse_q <= `CMSD_RST_CFG;
         sw_line_q  <= `CMSD_RST_CFG;
         sw_aux_q   <= `CMSD_RST_CFG;
      end
      else
      begin
         if (wr_en && wr_addr == `CMSD_OFF_MASK_A)
            mask_a_q <= wr_data;
         if (wr_en && wr_addr == `CMSD_OFF_MASK_B)
            mask_b_q <= wr_data;
         if (wr_en && wr_addr == `CMSD_OFF_INT_CFG)
            int_cfg_q <= wr_data;
         if (wr_en && wr_addr == `CMSD_OFF_SW_CFG)
            sw_cfg_q <= wr_data;
         if (wr_en && wr_addr == `CMSD_OFF_SW_LOOP)
            sw_loop_q <= wr_data;
         if (wr_en && wr_addr == `CMSD_OFF_SW_PULSE)
            sw_pulse_q <= wr_data;
         if (wr_en && wr_addr == `CMSD_OFF_SW_LINE)
            sw_line_q <= wr_data;
         if (wr_en && wr_addr == `CMSD_OFF_SW_AUX)
            sw_aux_q <= wr_data;
         // sticky pending status; a parallel read clears only the bits it saw, a serial read the bits set at the frame end
         stat_a_q <= (stat_a_q & ~((rd_done && rd_addr == `CMSD_OFF_STAT_A) ? rd_val : 8'h00)) | irq_src_a;
         stat_b_q <= (stat_b_q & ~((rd_done && rd_addr == `CMSD_OFF_STAT_B) ? rd_val : 8'h00)) | irq_src_b;
      end
   end

   // pending when an unmasked status bit is set
   wire pend = |(stat_a_q & ~mask_a_q) | |(stat_b_q & ~mask_b_q);
   wire int_act = pend & ~int_cfg_q[`CMSD_BIT_GMASK];

   // straps steer only in hardware mode, registers otherwise
   always @*
   begin
      eff_edge  = is_hw ? strap_s[29]    : sw_cfg_q[0];
      eff_rail  = is_hw ? strap_s[28:27] : sw_cfg_q[2:1];
      eff_loop1 = is_hw ? strap_s[26:25] : sw_loop_q[1:0];
      eff_loop2 = is_hw ? strap_s[24:23] : sw_loop_q[4:3];
      eff_pat   = is_hw ? strap_s[22:19] : {sw_aux_q[3:2], sw_cfg_q[4:3]};
   end

   // Decoded configuration and interrupt pin, all registered
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         irq_out             <= 1'b1;
         hw_mode             <= 1'b1;
         single_rail         <= 1'b1;
         ami_coding          <= 1'b0;
         clock_data_recovery <= 1'b1;
         analog_loop         <= 2'h0;
         digital_loop        <= 2'h0;
         remote_loop         <= 2'h0;
         inband_loop         <= 2'h0;
         tx_all_ones         <= 2'h0;
         tx_prbs             <= 2'h0;
         tx_power_down       <= 2'h0;
         pulse_shape_out     <= 8'h00;
         tx_high_z_out       <= 1'b0;
         jitter_atten_out    <= 2'h0;
         monitor_out         <= 2'h0;
         termination_out     <= 2'h0;
         rx_power_down_out   <= 2'h0;
      end
      else
      begin
         irq_out  <= int_cfg_q[`CMSD_BIT_POL_HIGH] ? int_act : ~int_act;
         hw_mode  <= is_hw;
         single_rail         <= ~eff_rail[1];
         ami_coding          <= (eff_rail == 2'h1);
         clock_data_recovery <= (eff_rail != 2'h3);
         analog_loop  <= {eff_loop2 == 2'h1, eff_loop1 == 2'h1};
         digital_loop <= {eff_loop2 == 2'h2, eff_loop1 == 2'h2};
         remote_loop  <= {eff_loop2 == 2'h3, eff_loop1 == 2'h3};
         inband_loop  <= is_hw ? 2'h0 : {sw_loop_q[5], sw_loop_q[2]};
         tx_all_ones   <= {eff_pat[3:2] == 2'h1, eff_pat[1:0] == 2'h1};
         tx_prbs       <= {eff_pat[3:2] == 2'h2, eff_pat[1:0] == 2'h2};
         tx_power_down <= {eff_pat[3:2] == 2'h3, eff_pat[1:0] == 2'h3};
         // remaining straps pass through in hardware mode
         pulse_shape_out   <= is_hw ? strap_s[18:11] : sw_pulse_q;
         tx_high_z_out     <= is_hw ? strap_s[10]    : sw_line_q[0];
         jitter_atten_out  <= is_hw ? strap_s[9:8]   : sw_line_q[2:1];
         monitor_out       <= is_hw ? strap_s[7:6]   : sw_line_q[4:3];
         termination_out   <= is_hw ? strap_s[5:4]   : sw_line_q[6:5];
         rx_power_down_out <= is_hw ? strap_s[3:2]   : sw_aux_q[1:0];
      end
   end

   // Receive rails retimed on the selected recovered clock edge
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rclk_prev_q     <= 1'b0;
         rx_rail_outputs <= 2'h0;
      end
      else
      begin
         rclk_prev_q <= link_s[2];
         // low picks rising, high picks falling
         if (eff_edge ? (rclk_prev_q & ~link_s[2]) : (~rclk_prev_q & link_s[2]))
            rx_rail_outputs <= link_s[1:0];
      end
   end
endmodule
`default_nettype wire

// file: tb/cmsd_checker_asserts.sv
// Assertions on strap decode and host port enables of cmsd_top
`default_nettype none
module cmsd_checker (
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // Pins
   input wire logic [1:0] mode_select,
   input wire logic [1:0] rail_coding_select,
   input wire logic [1:0] ch1_loop_select,
   input wire logic [3:0] tx_pattern_select,
   input wire logic       cs_n,
   input wire logic       strobe_or_read_n,
   // Outputs
   input wire logic       data_oe,
   input wire logic       serial_out_oe,
   input wire logic       hw_mode,
   input wire logic       single_rail,
   input wire logic       ami_coding,
   input wire logic       clock_data_recovery,
   input wire logic [1:0] analog_loop,
   input wire logic [1:0] digital_loop,
   input wire logic [1:0] remote_loop,
   input wire logic [1:0] inband_loop,
   input wire logic [1:0] tx_all_ones,
   input wire logic [1:0] tx_prbs,
   input wire logic [1:0] tx_power_down
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [9:0] prev_q;
   logic [3:0] settle_q;
   wire  [9:0] straps = {mode_select, rail_coding_select, ch1_loop_select, tx_pattern_select};
   // Decode is judged only once straps have outlived the synchroniser delay
   wire        ok     = (settle_q >= 4'h4) && (prev_q == straps);
   wire        hw     = ok && (mode_select == 2'h0);
   // Cycles since the last strap change
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         prev_q   <= 10'h000;
         settle_q <= 4'h0;
      end
      else
      begin
         prev_q <= straps;
         if (prev_q != straps)
            settle_q <= 4'h0;
         else if (settle_q != 4'hf)
            settle_q <= settle_q + 4'h1;
      end
   end
   a_mode_decode: assert property (ok |-> hw_mode == (mode_select == 2'h0))
      else $error("hw_mode does not follow mode pins");
   a_rail_decode: assert property (hw |-> single_rail == !rail_coding_select[1]
      && ami_coding == (rail_coding_select == 2'h1) && clock_data_recovery == (rail_coding_select != 2'h3))
      else $error("rail decode wrong");
   a_loop_decode: assert property (hw |-> {remote_loop[0], digital_loop[0], analog_loop[0]} ==
      {ch1_loop_select == 2'h3, ch1_loop_select == 2'h2, ch1_loop_select == 2'h1})
      else $error("loop decode wrong");
   a_pattern_decode: assert property (hw |-> {tx_power_down[0], tx_prbs[0], tx_all_ones[0]} ==
      {tx_pattern_select[1:0] == 2'h3, tx_pattern_select[1:0] == 2'h2, tx_pattern_select[1:0] == 2'h1})
      else $error("pattern decode wrong");
   a_no_inband: assert property (hw |-> inband_loop == 2'b00)
      else $error("inband loop on in strap mode");
   a_strap_sync: assert property ($changed(mode_select) && $past(ok) |=> $stable(hw_mode) [*2])
      else $error("mode change passed without synchroniser delay");
   a_oe_cause: assert property ($rose(data_oe) |-> $past(!cs_n && !strobe_or_read_n, 2))
      else $error("data_oe rose without select and strobe");
   a_oe_release: assert property (cs_n [*5] |-> !data_oe)
      else $error("data_oe held with select high");
   a_par_refused: assert property (ok && !mode_select[1] |-> !data_oe)
      else $error("parallel read answered in wrong mode");
   a_serial_idle: assert property (ok && mode_select != 2'h1 |-> !serial_out_oe)
      else $error("serial output driven outside serial mode");
   c_hw_remote: cover property (hw && ch1_loop_select == 2'h3);
   c_read: cover property ($rose(data_oe));
   c_ds_read: cover property (ok && mode_select == 2'h2 && data_oe);
endmodule
bind cmsd_top cmsd_checker u_checker (.*);
`default_nettype wire

// file: tb/cmsd_host.sv
// Host model driving the parallel register port
`default_nettype none
module cmsd_host (
   // Clock and mode
   input  wire logic       clock,
   input  wire logic       ds_mode,
   // Parallel port pins
   output var  logic       cs_n,
   output var  logic [5:0] addr,
   output var  logic [7:0] data_in,
   output var  logic       strobe_or_read_n,
   output var  logic       dir_or_write_n,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      cs_n             = 1'b1;
      addr             = 6'h00;
      data_in          = 8'h00;
      strobe_or_read_n = 1'b1;
      dir_or_write_n   = 1'b1;
   end
   // One byte access: pins held six edges, then a five-edge gap
   // select, strobes per mode
   task automatic acc(input logic rd, input logic [5:0] a, input logic [7:0] wd, input logic sel,
                      output logic [7:0] rdat, output logic oe);
      @(posedge clock);
      cs_n             <= !sel;
      addr             <= a;
      data_in          <= wd;
      strobe_or_read_n <= !(ds_mode | rd);
      dir_or_write_n   <= rd;
      oe = 1'b0;
      repeat (6)
      begin
         @(posedge clock);
         oe = oe | data_oe;
      end
      rdat = data_out;
      // Released address and data lines invert so a stale value never looks held
      cs_n             <= 1'b1;
      strobe_or_read_n <= 1'b1;
      dir_or_write_n   <= 1'b1;
      addr             <= ~a;
      data_in          <= ~wd;
      repeat (5) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// file: tb/cmsd_top_tb.sv
// Self-checking bench for the control mode and strap decoder
`include "cmsd_defines.vh"
`default_nettype none
module cmsd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  mode_select = 2'h0, rail_coding_select = 2'h0, ch1_loop_select = 2'h0, ch2_loop_select = 2'h0;
   logic [1:0]  jitter_atten_place = 2'h0, monitor_enable = 2'h0, termination_select = 2'h0, rx_power_down = 2'h0;
   logic        clock = 1'b0, rst = 1'b1, sclk = 1'b0, shift_edge_select = 1'b0, serial_in = 1'b0;
   logic        rx_edge_select = 1'b0, tx_high_z = 1'b0, recovered_clock = 1'b0;
   logic [1:0]  rx_rail_in = 2'h0;
   logic [3:0]  tx_pattern_select = 4'h0;
   logic [7:0]  pulse_shape_select = 8'h00, irq_src_a = 8'h00, irq_src_b = 8'h00;
   logic        cs_n, strobe_or_read_n, dir_or_write_n, ds_mode, serial_out, serial_out_oe, data_oe, irq_out;
   logic        hw_mode, single_rail, ami_coding, clock_data_recovery, tx_high_z_out;
   logic [5:0]  addr;
   logic [7:0]  data_in, data_out, pulse_shape_out;
   logic [1:0]  rx_rail_outputs, analog_loop, digital_loop, remote_loop, inband_loop, tx_all_ones, tx_prbs;
   logic [1:0]  tx_power_down, jitter_atten_out, monitor_out, termination_out, rx_power_down_out;
   logic [31:0] seed = 32'h82a3;
   int          mismatches = 0, tests_run = 0, cycles = 0;
   assign ds_mode = (mode_select == `CMSD_MODE_PAR_DS);
   cmsd_top dut (.*);
   cmsd_host host (.*);
   // Clocks: system 10 ns, receive 160 ns with an unrelated phase
   initial
   begin
      forever #5 clock = ~clock;
   end
   initial
   begin
      #37;
      forever #80 recovered_clock = ~recovered_clock;
   end
   // Rails step a quarter period after every edge
   always @(recovered_clock)
      rx_rail_in <= #40 rx_rail_in + 2'h1;
   // Hang guard, far above the thousand or so cycles expected
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches = mismatches + 1;
         summarize();
      end
   end
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // Select code to {code 3, code 2, code 1}
   function automatic logic [2:0] dec(input logic [1:0] c);
      return {c == 2'h3, c == 2'h2, c == 2'h1};
   endfunction
   // Rail code to {single rail, alternate mark coding, recovery on}
   function automatic logic [2:0] rail_exp(input logic [1:0] c);
      return {!c[1], c == 2'h1, c != 2'h3};
   endfunction
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run = tests_run + 1;
      if (e !== g)
      begin
         mismatches = mismatches + 1;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Interrupt output settles within four edges of a status or mask change
   task automatic irq_is(input string nm, input logic e);
      repeat (4) @(posedge clock);
      cmp(nm, {31'h0, e}, {31'h0, irq_out});
   endtask
   task automatic pulse(input int b, input logic [7:0] v);
      @(posedge clock);
      if (b == 1)
         irq_src_b <= v;
      else
         irq_src_a <= v;
      @(posedge clock);
      irq_src_a <= 8'h00;
      irq_src_b <= 8'h00;
   endtask
   initial
   begin : main
      logic [7:0]  d, v;
      logic        oe;
      logic [31:0] r;
      logic [5:0]  mo, so;
      int          i, b;
      repeat (5) @(posedge clock);
      cmp("reset_out", 4'hc, {irq_out, hw_mode, data_oe, serial_out_oe});
      rst <= 1'b0;
      // Strap mode: every code of the rail, channel 1 loop and low pattern fields, the rest random
      for (i = 0; i < 12; i++)
      begin
         @(posedge clock);
         r = rnd();
         rail_coding_select <= i[1:0];
         ch1_loop_select    <= i[1:0];
         tx_pattern_select  <= {r[1:0], i[1:0]};
         ch2_loop_select    <= r[3:2];
         pulse_shape_select <= r[11:4];
         tx_high_z          <= r[12];
         jitter_atten_place <= r[14:13];
         monitor_enable     <= r[16:15];
         termination_select <= r[18:17];
         rx_power_down      <= r[20:19];
         repeat (6) @(posedge clock);
         cmp("hw_mode", 1, hw_mode);
         cmp("rail", rail_exp(rail_coding_select), {single_rail, ami_coding, clock_data_recovery});
         cmp("loop1", dec(ch1_loop_select), {remote_loop[0], digital_loop[0], analog_loop[0]});
         cmp("loop2", dec(ch2_loop_select), {remote_loop[1], digital_loop[1], analog_loop[1]});
         cmp("pattern1", dec(tx_pattern_select[1:0]), {tx_power_down[0], tx_prbs[0], tx_all_ones[0]});
         cmp("inband", 0, inband_loop);
         cmp("hw_pins", {pulse_shape_select, tx_high_z, jitter_atten_place, monitor_enable, termination_select,
             rx_power_down}, {pulse_shape_out, tx_high_z_out, jitter_atten_out, monitor_out, termination_out,
             rx_power_down_out});
      end
      host.acc(1'b1, `CMSD_OFF_MASK_A, 8'h00, 1'b1, d, oe);
      cmp("oe_strap_mode", 0, oe);
      // Receive rails follow the selected recovered clock edge
      for (i = 0; i < 6; i++)
      begin
         @(posedge clock);
         rx_edge_select <= i[0];
         repeat (20) @(posedge clock);
         if (i[0])
            @(negedge recovered_clock);
         else
            @(posedge recovered_clock);
         v = {6'h00, rx_rail_in};
         repeat (6) @(posedge clock);
         cmp("rx_rail", v, rx_rail_outputs);
      end
      // Software mode: straps ignored, registers rule
      @(posedge clock);
      mode_select     <= `CMSD_MODE_PAR_RW;
      ch1_loop_select <= 2'h3;
      repeat (6) @(posedge clock);
      cmp("sw_mode", 0, {hw_mode, remote_loop[0], digital_loop[0], analog_loop[0]});
      host.acc(1'b0, `CMSD_OFF_SW_LOOP, 8'h24, 1'b1, d, oe);
      repeat (2) @(posedge clock);
      cmp("inband_sw", 2'h3, inband_loop);
      for (i = 0; i < 5; i++)
      begin
         mo = (i == 0) ? `CMSD_OFF_MASK_A : (i == 1) ? `CMSD_OFF_MASK_B : (i == 2) ? `CMSD_OFF_STAT_A :
              (i == 3) ? `CMSD_OFF_STAT_B : 6'h3f;
         host.acc(1'b0, 6'h3f, 8'h77, 1'b1, d, oe);
         host.acc(1'b1, mo, 8'h00, 1'b1, d, oe);
         cmp("reg_reset", (i < 2) ? 8'hff : 8'h00, d);
      end
      // Status is read-only
      host.acc(1'b0, `CMSD_OFF_STAT_A, 8'hff, 1'b1, d, oe);
      host.acc(1'b1, `CMSD_OFF_STAT_A, 8'h00, 1'b1, d, oe);
      cmp("status_ro", 8'h00, d);
      // Interrupt per bank: raise, clear, mask, global mask, polarity
      for (b = 0; b < 2; b++)
      begin
         mo = b ? `CMSD_OFF_MASK_B : `CMSD_OFF_MASK_A;
         so = b ? `CMSD_OFF_STAT_B : `CMSD_OFF_STAT_A;
         v = 8'h01 << (rnd() % 8);
         host.acc(1'b0, mo, 8'h00, 1'b1, d, oe);
         pulse(b, v);
         irq_is("irq_raise", 1'b0);
         host.acc(1'b1, so, 8'h00, 1'b1, d, oe);
         cmp("status", v, d);
         irq_is("irq_clear", 1'b1);
         host.acc(1'b0, mo, v, 1'b1, d, oe);
         pulse(b, v);
         irq_is("irq_masked", 1'b1);
         host.acc(1'b0, mo, 8'h00, 1'b1, d, oe);
         irq_is("irq_unmasked", 1'b0);
         host.acc(1'b0, `CMSD_OFF_INT_CFG, 8'h01, 1'b1, d, oe);
         irq_is("irq_global", 1'b1);
         host.acc(1'b0, `CMSD_OFF_INT_CFG, 8'h02, 1'b1, d, oe);
         irq_is("irq_pol_high", 1'b1);
         host.acc(1'b1, so, 8'h00, 1'b1, d, oe);
         irq_is("irq_pol_idle", 1'b0);
         host.acc(1'b0, `CMSD_OFF_INT_CFG, 8'h00, 1'b1, d, oe);
      end
      // Strobe and direction mode: random write and read back
      @(posedge clock);
      mode_select <= `CMSD_MODE_PAR_DS;
      repeat (6) @(posedge clock);
      for (i = 0; i < 4; i++)
      begin
         v = rnd();
         host.acc(1'b0, `CMSD_OFF_MASK_B, v, 1'b1, d, oe);
         host.acc(1'b1, `CMSD_OFF_MASK_B, 8'h00, 1'b1, d, oe);
         cmp("ds_readback", {1'b1, v}, {oe, d});
      end
      host.acc(1'b1, `CMSD_OFF_MASK_B, 8'h00, 1'b0, d, oe);
      cmp("oe_no_select", 0, oe);
      // Serial read; bits taken at the fall after each shift
      mode_select <= `CMSD_MODE_SERIAL;
      host.cs_n <= 1'b0;
      r = {25'h0, `CMSD_OFF_MASK_B, 1'b1};
      for (i = 0; i < 33; i++)
      begin
         repeat (5) @(posedge clock);
         sclk <= i[0];
         serial_in <= r[i/2];
         if (i > 17 && !i[0])
            d[i/2-9] = serial_out;
      end
      cmp("serial_read", {1'b1, v}, {serial_out_oe, d});
      host.cs_n <= 1'b1;
      summarize();
   end
endmodule
`default_nettype wire
